/* File: core/sip_pkg.sv */
// package for the interrupt pulse generator: timing, event layout, modes
// assumes a single 50 MHz system clock and event strobes from that domain
package sip_pkg;

   // clock and pulse timing
   localparam int CLK_HZ        = 50_000_000;
   localparam int PULSE_TIME_US = 100;
   localparam int GAP_TIME_US   = 100;
   localparam int PULSE_CYC_DEF = PULSE_TIME_US * (CLK_HZ / 1_000_000);
   localparam int GAP_CYC_DEF   = GAP_TIME_US * (CLK_HZ / 1_000_000);
   localparam int CNT_W         = 16;

   // event vector widths
   localparam int WAKE_W = 8;
   localparam int FAIL_W = 16;

   // failure bits that force restart or fail-safe, plus power-on
   localparam int FB_UNDERVOLT  = 0;
   localparam int FB_WATCHDOG   = 1;
   localparam int FB_SHORT      = 2;
   localparam int FB_TSD_SEVERE = 3;
   localparam int FB_FAIL_OUT   = 4;
   localparam int FB_POWER_ON   = 5;
   localparam logic [FAIL_W-1:0] FAIL_NO_IRQ =
      (FAIL_W'(1) << FB_UNDERVOLT) | (FAIL_W'(1) << FB_WATCHDOG) |
      (FAIL_W'(1) << FB_SHORT)     | (FAIL_W'(1) << FB_TSD_SEVERE) |
      (FAIL_W'(1) << FB_FAIL_OUT)  | (FAIL_W'(1) << FB_POWER_ON);

   // reset values
   localparam logic CLASS_RESET = 1'h0;
   localparam logic PIN_RESET   = 1'h1;

   typedef enum logic [2:0] {
      MODE_INIT,
      MODE_NORMAL,
      MODE_STOP,
      MODE_SLEEP,
      MODE_RESTART,
      MODE_FAILSAFE
   } sip_mode_e;

   typedef struct packed {
      logic [WAKE_W-1:0] wake_a;
      logic [WAKE_W-1:0] wake_b;
      logic              can_to;
      logic [FAIL_W-1:0] fail;
   } sip_evt_s;

endpackage

/* File: core/sip_interval_timer.sv */
// down-counter that flags the last cycle of a loaded interval
// assumes load is a one-cycle strobe on sys_clk; reload may coincide
// with the expiry cycle
`timescale 1ns/1ps
`default_nettype none
module sip_interval_timer #(
   parameter int W = 16
) (
   // clock and reset
   input  wire logic         sys_clk,
   input  wire logic         reset_n,
   // control
   input  wire logic         load,
   input  wire logic [W-1:0] load_val,
   // status
   output logic              expired
);
   logic [W-1:0] cnt;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt <= '0;
      end else if (load) begin
         cnt <= load_val;
      end else if (cnt != '0) begin
         cnt <= cnt - W'(1);
      end
   end

   // a value of n expires in the nth cycle after the load
   assign expired = (cnt == W'(1));
endmodule
`default_nettype wire

/* File: core/sip_irq_pulse.sv */
// interrupt pulse generator: event collection, status, pin sequencing
// assumes events, clears and mode come from sys_clk logic; int pin
// input arrives asynchronously from the board
`timescale 1ns/1ps
`default_nettype none
module sip_irq_pulse #(
   parameter int PULSE_CYCLES = sip_pkg::PULSE_CYC_DEF,
   parameter int GAP_CYCLES   = sip_pkg::GAP_CYC_DEF
) (
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              reset_n,
   // chip mode
   input  wire sip_pkg::sip_mode_e chip_mode,
   input  wire logic              stop_cmd,
   // configuration
   input  wire logic              class_wr,
   input  wire logic              class_wdata,
   input  wire logic [7:0]        wake_a_en,
   input  wire logic [7:0]        wake_b_en,
   input  wire logic              can_timeout_irq_mask,
   // events and levels
   input  wire sip_pkg::sip_evt_s  event_in,
   input  wire logic [7:0]        wake_level_in,
   // host read-and-clear
   input  wire sip_pkg::sip_evt_s  status_clr,
   // status
   output sip_pkg::sip_evt_s      status,
   output logic                   class_global,
   output logic [7:0]             wake_level_status,
   output logic                   cfg_level,
   // interrupt pin
   input  wire logic              int_pin_i,
   output logic                   int_pin_o,
   output logic                   int_pin_oe
);
   import sip_pkg::*;

   typedef enum logic [1:0] {S_IDLE, S_PULSE, S_GAP} sip_state_e;

   sip_state_e st;
   sip_evt_s   pend;
   sip_evt_s   elig;
   sip_evt_s   evt_irq;
   sip_evt_s   evt_direct;
   logic       stop_req;
   logic       mode_ok;
   logic       take;
   logic       tmr_load;
   logic [CNT_W-1:0] tmr_val;
   logic       tmr_exp;
   logic       pin_s1;
   logic       pin_s2;

   // which events may raise a pulse
   always_comb begin
      elig.wake_a = wake_a_en;
      elig.wake_b = wake_b_en;
      elig.can_to = can_timeout_irq_mask;
      elig.fail   = class_global ? ~FAIL_NO_IRQ : '0;
   end
   // excluded flags still latch, they just bypass the pulse path
   assign evt_irq    = event_in & elig;
   assign evt_direct = event_in & ~elig;

   // pulses only in normal and stop mode; mode itself is never driven
   assign mode_ok = (chip_mode == MODE_NORMAL)
                    || (chip_mode == MODE_STOP);
   assign take = (st == S_IDLE) && mode_ok && ((pend != '0) || stop_req);

   // class select register
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         class_global <= CLASS_RESET;
      end else if (class_wr) begin
         class_global <= class_wdata;
      end
   end

   // pending events; host clears act only on visible status
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pend <= '0;
      end else if (take) begin
         pend <= evt_irq;
      end else begin
         pend <= pend | evt_irq;
      end
   end

   // stop entry with uncleared wake status forces one pulse
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         stop_req <= 1'h0;
      end else if (stop_cmd && ((status.wake_a | status.wake_b) != '0)) begin
         stop_req <= 1'h1;
      end else if (take) begin
         stop_req <= 1'h0;
      end
   end

   // visible status: set wins over a same-cycle clear
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         status <= '0;
      end else begin
         status <= (status & ~status_clr) | evt_direct
                   | (take ? pend : '0);
      end
   end

   // level status is a plain copy, no event memory
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         wake_level_status <= '0;
      end else begin
         wake_level_status <= wake_level_in;
      end
   end

   // pulse sequencer
   assign tmr_load = take || ((st == S_PULSE) && tmr_exp);
   assign tmr_val  = take ? CNT_W'(PULSE_CYCLES) : CNT_W'(GAP_CYCLES);

   sip_interval_timer #(
      .W        (CNT_W)
   ) u_timer (
      .sys_clk  (sys_clk),
      .reset_n  (reset_n),
      .load     (tmr_load),
      .load_val (tmr_val),
      .expired  (tmr_exp)
   );

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         st <= S_IDLE;
      end else begin
         case (st)
            S_IDLE: begin
               if (take) begin
                  st <= S_PULSE;
               end
            end
            S_PULSE: begin
               if (tmr_exp) begin
                  st <= S_GAP;
               end
            end
            S_GAP: begin
               if (tmr_exp) begin
                  st <= S_IDLE;
               end
            end
            default: begin
               st <= S_IDLE;
            end
         endcase
      end
   end

   // pin drive; low only while pulsing
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         int_pin_o <= PIN_RESET;
      end else begin
         int_pin_o <= !(take || ((st == S_PULSE) && !tmr_exp));
      end
   end

   // released in init so the strap level can be read
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         int_pin_oe <= 1'h0;
      end else begin
         int_pin_oe <= (chip_mode != MODE_INIT);
      end
   end

   // pin level synchroniser and configuration capture
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_s1 <= 1'h0;
         pin_s2 <= 1'h0;
      end else begin
         pin_s1 <= int_pin_i;
         pin_s2 <= pin_s1;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_level <= 1'h0;
      end else if (chip_mode == MODE_INIT) begin
         cfg_level <= pin_s2;
      end
   end

   // helper counters of pin low and high time
   logic [CNT_W-1:0] lo_len;
   logic [CNT_W-1:0] hi_len;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         lo_len <= '0;
         hi_len <= '1;
      end else begin
         lo_len <= int_pin_o ? '0 : lo_len + CNT_W'(1);
         hi_len <= !int_pin_o ? '0 :
                   (hi_len == '1) ? hi_len : hi_len + CNT_W'(1);
      end
   end

   a_pulse_width: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      $rose(int_pin_o) |-> (lo_len == CNT_W'(PULSE_CYCLES)))
      else $error("interrupt pulse width wrong");

   a_gap_min: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      $fell(int_pin_o) |-> ($past(hi_len) >= CNT_W'(GAP_CYCLES)))
      else $error("gap between pulses too short");

   a_init_released: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (chip_mode == MODE_INIT) |=> !int_pin_oe)
      else $error("pin driven during init mode");

   a_idle_drives_high: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (chip_mode == MODE_NORMAL) && (st == S_IDLE) && !take
      |=> int_pin_oe && int_pin_o)
      else $error("idle pin not driven high");

   a_status_transfer: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      $fell(int_pin_o) |-> ((status & $past(pend)) == $past(pend)))
      else $error("pending events not moved to status");

   a_status_hold: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (status_clr == '0) |=> ((status & $past(status)) == $past(status)))
      else $error("status bit lost without clear");

   a_stop_pulse: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      stop_cmd && ((status.wake_a | status.wake_b) != '0) && (st == S_IDLE)
      && (chip_mode == MODE_STOP) |-> ##[1:2] !int_pin_o)
      else $error("stop entry with wake status gave no pulse");

   a_pending_kept: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (st != S_IDLE) && (pend != '0) |=> (pend != '0))
      else $error("pending event dropped during pulse");
endmodule
`default_nettype wire

/* File: verification/sip_host_model.sv */
// host side model: reads and clears status, sees the interrupt pin
// assumes sip_irq_pulse drives int pin; config strap resistor when the pin is released
`timescale 1ns/1ps
`default_nettype none
module sip_host_model
   import sip_pkg::*;
#(
   parameter int   HOLD  = 3,
   parameter logic STRAP = 1'h1
) (
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              reset_n,
   // device side
   input  wire sip_pkg::sip_evt_s status,
   input  wire logic              int_pin_o,
   input  wire logic              int_pin_oe,
   output sip_pkg::sip_evt_s      status_clr,
   output logic                   int_pin_i
);
   int   stable;
   logic recheck;
   logic reread_ok;
   // strap level shows only while the device leaves the pin alone
   assign int_pin_i = int_pin_oe ? int_pin_o : STRAP;
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         stable     <= 0;
         status_clr <= '0;
         recheck    <= 1'h0;
         reread_ok  <= 1'h0;
      end else begin
         status_clr <= '0;
         recheck    <= (status_clr != '0);
         if (recheck) begin
            reread_ok <= (status == '0);
         end
         if (status == '0 || status_clr != '0) begin
            stable <= 0;
         end else begin
            stable <= stable + 1;
         end
         // slow reader: clears land during pulses too
         if (stable == HOLD - 1 && status_clr == '0) begin
            status_clr <= status;
         end
      end
   end
endmodule
`default_nettype wire

/* File: verification/test_sip_irq_pulse.sv */
// self-checking bench for sip_irq_pulse with a host model
// assumes short pulse and gap counts of 4 cycles
`timescale 1ns/1ps
`default_nettype none
module test_sip_irq_pulse;
   import sip_pkg::*;
   localparam int PC = 4;
   localparam int GC = 4;
   logic        sys_clk, reset_n, stop_cmd, class_wr, class_wdata;
   logic        can_timeout_irq_mask, class_global, cfg_level;
   logic        int_pin_i, int_pin_o, int_pin_oe, last_pin, seen_pulse;
   logic [7:0]  wake_a_en, wake_b_en, wake_level_in, wake_level_status;
   sip_mode_e   chip_mode;
   sip_evt_s    event_in, status_clr, status, e;
   sip_evt_s    exp_q[$];
   int          fails, check_count, cyc, lowc, gapc, i;
   int unsigned r;

   sip_irq_pulse #(.PULSE_CYCLES(PC), .GAP_CYCLES(GC)) sip_irq_pulse_inst (
      .sys_clk(sys_clk), .reset_n(reset_n), .chip_mode(chip_mode),
      .stop_cmd(stop_cmd), .class_wr(class_wr), .class_wdata(class_wdata),
      .wake_a_en(wake_a_en), .wake_b_en(wake_b_en),
      .can_timeout_irq_mask(can_timeout_irq_mask), .event_in(event_in),
      .wake_level_in(wake_level_in), .status_clr(status_clr),
      .status(status), .class_global(class_global),
      .wake_level_status(wake_level_status), .cfg_level(cfg_level),
      .int_pin_i(int_pin_i), .int_pin_o(int_pin_o), .int_pin_oe(int_pin_oe));
   sip_host_model sip_host_model_inst (
      .sys_clk(sys_clk), .reset_n(reset_n), .status(status),
      .int_pin_o(int_pin_o), .int_pin_oe(int_pin_oe),
      .status_clr(status_clr), .int_pin_i(int_pin_i));

   task automatic chk(string what, logic [63:0] ex, logic [63:0] got);
      check_count++;
      if (ex !== got) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, ex, got);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // a pulse expected from this event is noted before it is sent
   task automatic fire(sip_evt_s ev, bit pulse);
      if (pulse) exp_q.push_back(ev);
      @(negedge sys_clk) event_in = ev;
      @(negedge sys_clk) event_in = '0;
   endtask
   task automatic settle;
      repeat (40) @(negedge sys_clk);
      chk("unseen pulses", 0, exp_q.size());
      chk("reread clear", 1, sip_host_model_inst.reread_ok);
   endtask

   initial begin
      sys_clk = 1'h0;
      forever #10 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc > 20000) begin
         fails++;
         tally_and_finish();
      end
   end
   // pin watcher: width, gap, status at each falling edge
   always @(negedge sys_clk) begin
      if (reset_n && int_pin_oe) begin
         if (last_pin && !int_pin_o) begin
            if (seen_pulse) chk("gap ok", 1, gapc >= GC + 1);
            if (exp_q.size() == 0) chk("spurious pulse", 0, 1);
            else chk("status at fall", exp_q.pop_front(), status);
            lowc = 0;
            seen_pulse = 1'h1;
         end
         if (!int_pin_o) lowc++;
         else if (!last_pin) chk("pulse width", PC, lowc);
         gapc = int_pin_o ? gapc + 1 : 0;
      end
      last_pin = int_pin_o;
   end

   initial begin
      reset_n = 1'h0; stop_cmd = 1'h0; class_wr = 1'h0; class_wdata = 1'h0;
      can_timeout_irq_mask = 1'h1; wake_a_en = 8'hff; wake_b_en = 8'h0f;
      wake_level_in = 8'h00; chip_mode = MODE_INIT; event_in = '0;
      last_pin = 1'h1; seen_pulse = 1'h0;
      r = $urandom(32'h7114);
      repeat (16) @(negedge sys_clk);
      reset_n = 1'h1;
      repeat (5) @(negedge sys_clk);
      chk("oe in init", 0, int_pin_oe);
      chk("cfg level", 1, cfg_level);
      chk("class reset", 0, class_global);
      chk("pin idle", 1, int_pin_o);
      chk("pulse cycles", 16'h1388, PULSE_CYC_DEF);
      chk("gap cycles", 16'h1388, GAP_CYC_DEF);
      chip_mode = MODE_NORMAL;
      repeat (3) @(negedge sys_clk);
      chk("oe normal", 1, int_pin_oe);
      e = '0; e.wake_a[$urandom % 8] = 1'h1;
      fire(e, 1);
      settle();
      // disabled wake source latches, stop command then pulses
      e = '0; e.wake_b = 8'h10 << ($urandom % 4);
      fire(e, 0);
      chk("latched", e, status);
      exp_q.push_back(e);
      stop_cmd = 1'h1;
      chip_mode = MODE_STOP;
      @(negedge sys_clk) stop_cmd = 1'h0;
      settle();
      chip_mode = MODE_NORMAL;
      for (i = 0; i < 2; i++) begin
         e = '0; e.can_to = 1'h1; can_timeout_irq_mask = i[0];
         fire(e, i[0]);
         settle();
      end
      for (i = 0; i < 14; i++) begin
         if (i == 7) begin
            class_wr = 1'h1; class_wdata = 1'h1;
            @(negedge sys_clk) class_wr = 1'h0;
            chk("class global", 1, class_global);
         end
         e = '0; e.fail[i % 7] = 1'h1;
         fire(e, i == 13);
         repeat (12) @(negedge sys_clk);
      end
      e = '0; e.can_to = 1'h1; can_timeout_irq_mask = 1'h0;
      fire(e, 0);
      settle();
      for (i = 0; i < 4; i++) begin
         wake_level_in = 8'($urandom);
         repeat (2) @(negedge sys_clk);
         chk("level copy", wake_level_in, wake_level_status);
         chk("level not latched", 0, status);
      end
      settle();
      e = '0; e.wake_b[1] = 1'h1; chip_mode = MODE_SLEEP;
      fire(e, 1);
      repeat (20) @(negedge sys_clk);
      chk("held in sleep", 1, exp_q.size());
      chip_mode = MODE_NORMAL;
      settle();
      e = '0; e.wake_a[$urandom % 8] = 1'h1;
      fire(e, 1);
      repeat (2) @(negedge sys_clk);
      e = '0; e.fail[6 + $urandom % 10] = 1'h1;
      fire(e, 1);
      settle();
      tally_and_finish();
   end
endmodule
`default_nettype wire
